/* File: ars_alu.v */
/*
 * Combinational eight-function ALU of one 4-bit slice with carry,
 * propagate, generate, negative and overflow terms.
 * Assumes operands are already in true polarity.
 */
`timescale 1ns/100ps
`include "ars_defs.vh"

module ars_alu #(
	parameter WIDTH = 4
) (
	// operands and instruction
	input wire [WIDTH-1:0] regOperand,
	input wire [WIDTH-1:0] dataOperand,
	input wire [2:0] instr,
	// results
	output reg [WIDTH-1:0] result,
	output wire arith,
	output wire carryOut,
	output wire carryProp,
	output wire carryGen,
	output wire negative,
	output wire overflow
);

	wire carryIn;
	wire [WIDTH:0] sum;
	wire [WIDTH-1:0] bitProp;
	wire [WIDTH-1:0] bitGen;
	wire [WIDTH-1:0] genChain;

	assign arith = (instr[2:1] == 2'h0);
	// lowest instruction bit doubles as active-low carry in
	assign carryIn = ~instr[`ARS_I_CIN];
	assign sum = {1'b0, regOperand} + {1'b0, dataOperand} + {{WIDTH{1'b0}}, carryIn};
	assign carryOut = sum[WIDTH];
	assign bitProp = regOperand | dataOperand;
	assign bitGen = regOperand & dataOperand;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gChain
			if (i == 0) begin : gFirst
				assign genChain[i] = bitGen[i];
			end else begin : gRest
				assign genChain[i] = bitGen[i] | (bitProp[i] & genChain[i-1]);
			end
		end
	endgenerate

	assign carryProp = &bitProp;
	assign carryGen = genChain[WIDTH-1];

	always @* begin
		case (instr)
			`ARS_I_ADDC: result = sum[WIDTH-1:0];
			`ARS_I_ADD: result = sum[WIDTH-1:0];
			`ARS_I_AND: result = regOperand & dataOperand;
			`ARS_I_LOAD: result = dataOperand;
			`ARS_I_XFER: result = regOperand;
			`ARS_I_OR: result = regOperand | dataOperand;
			`ARS_I_XOR: result = regOperand ^ dataOperand;
			`ARS_I_LOADC: result = ~dataOperand;
			default: result = {WIDTH{1'b0}};
		endcase
	end

	assign negative = result[WIDTH-1];
	assign overflow = arith & (regOperand[WIDTH-1] == dataOperand[WIDTH-1])
		& (result[WIDTH-1] != regOperand[WIDTH-1]);

endmodule

/* File: ars_ctrl_model.sv */
/*
 * Microprogram controller model: drives slice pins in high and low phases.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
`timescale 1ns/100ps
module ars_ctrl_model (
	// clock
	input wire core_clk,
	// slice pins
	output reg sliceClock,
	output reg executeN,
	output reg outputEnableN,
	output reg topSliceSelect,
	output reg [2:0] registerAddressField,
	output reg [2:0] instructionField,
	output reg [3:0] dataBusInN
);
	initial begin
		sliceClock = 1'h0;
		executeN = 1'h1;
		outputEnableN = 1'h0;
		topSliceSelect = 1'h0;
		registerAddressField = 3'h0;
		instructionField = 3'h4;
		dataBusInN = 4'hf;
	end
	task setMode(input top, input oen);
		begin
			@(posedge core_clk);
			topSliceSelect <= top;
			outputEnableN <= oen;
		end
	endtask
	// fields change only after the rise, so the load at the rise sees the old operation
	task phaseHigh(input [2:0] src, input [2:0] ins, input [3:0] dn);
		begin
			@(posedge core_clk);
			sliceClock <= 1'h1;
			repeat (4) @(posedge core_clk);
			registerAddressField <= src;
			instructionField <= ins;
			dataBusInN <= dn;
			executeN <= 1'h1;
			repeat (8) @(posedge core_clk);
		end
	endtask
	// destination switched while execute is still high, so no stray write hits the source
	task phaseLow(input [2:0] dst, input ex);
		begin
			@(posedge core_clk);
			sliceClock <= 1'h0;
			repeat (3) @(posedge core_clk);
			registerAddressField <= dst;
			repeat (3) @(posedge core_clk);
			executeN <= ex;
			repeat (8) @(posedge core_clk);
		end
	endtask
endmodule

/* File: ars_defs.vh */
/*
 * Shared constants for the register stack slice: register offsets, field
 * positions, instruction codes and bus answer codes.
 * Assumes it is included by bare name into every design file that needs it.
 */
`ifndef ARS_DEFS_VH
`define ARS_DEFS_VH

// slice geometry
`define ARS_SLICE_W 4
`define ARS_WORDS 8
`define ARS_ADDR_W 3
`define ARS_MSB 3

// instruction field, upper to lower bit
`define ARS_I_ADDC 3'h0
`define ARS_I_ADD 3'h1
`define ARS_I_AND 3'h2
`define ARS_I_LOAD 3'h3
`define ARS_I_XFER 3'h4
`define ARS_I_OR 3'h5
`define ARS_I_XOR 3'h6
`define ARS_I_LOADC 3'h7
`define ARS_I_CIN 0

// register map, byte addresses
`define ARS_OFS_CTRL 4'h0
`define ARS_OFS_STATUS 4'h4
`define ARS_OFS_CYCLES 4'h8
`define ARS_OFS_WRITES 4'hc
`define ARS_ADDR_BITS 4

// control fields
`define ARS_CTRL_DRIVE 0
`define ARS_CTRL_HOLD 1
`define ARS_CTRL_RESET 2'h1

// status fields
`define ARS_ST_OUT_LO 0
`define ARS_ST_ZERO 4
`define ARS_ST_NEG 5
`define ARS_ST_OVF 6
`define ARS_ST_CARRY 7
`define ARS_ST_TOP 8
`define ARS_ST_CLK 9
`define ARS_ST_EXEC 10

// bus answers
`define ARS_RESP_OKAY 2'h0
`define ARS_RESP_DECERR 2'h3

`endif

/* File: ars_reg_ram.v */
/*
 * Eight-word register RAM of the slice with a registered read port that
 * acts as the operand latch.
 * Assumes one clock; write and read enables come from the phase logic.
 */
`timescale 1ns/100ps

module ars_reg_ram #(
	parameter WIDTH = 4,
	parameter DEPTH = 8,
	parameter ADDR_W = 3
) (
	// clock
	input wire core_clk,
	// write port
	input wire writeEnable,
	input wire [ADDR_W-1:0] writeAddr,
	input wire [WIDTH-1:0] writeData,
	// read port
	input wire readEnable,
	input wire [ADDR_W-1:0] readAddr,
	output reg [WIDTH-1:0] readData
);

	// no reset: contents stay unknown until the first write
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	always @(posedge core_clk) begin
		if (writeEnable) begin
			mem[writeAddr] <= writeData;
		end
	end

	// latch tracks the RAM only while enabled, then holds
	always @(posedge core_clk) begin
		if (readEnable) begin
			readData <= mem[readAddr];
		end
	end

endmodule

/* File: ars_slice_chk.sv */
/*
 * Checker for the register stack slice: pin and bus relations at the top ports.
 * Assumes it is bound to every ars_slice_top and sees only its ports.
 */
`timescale 1ns/100ps
module ars_slice_chk #(
	parameter WIDTH = 4
) (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// bus handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	// slice pins
	input wire sliceClock,
	input wire executeN,
	input wire outputEnableN,
	input wire topSliceSelect,
	input wire [2:0] instructionField,
	input wire [WIDTH-1:0] resultBusOutN,
	input wire resultBusOe,
	input wire rippleCarryN,
	input wire propagateN,
	input wire generateN,
	input wire zeroOut
);
	reg [2:0] upCnt_reg;
	wire up;
	// pin relations only hold once the synchroniser has been flushed after reset
	always @(posedge core_clk) begin
		if (reset)
			upCnt_reg <= 3'h0;
		else if (upCnt_reg != 3'h7)
			upCnt_reg <= upCnt_reg + 3'h1;
	end
	assign up = upCnt_reg == 3'h7;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_ZERO_DATA: assert property (zeroOut == 1'h0)
		else $error("zero line data not low");
	AST_OE_OFF: assert property ((up && outputEnableN)[*4] |-> !resultBusOe)
		else $error("result bus driven while disabled");
	AST_LOAD_CAUSE: assert property (up && $changed(resultBusOutN) |-> $past(sliceClock, 2) && !$past(executeN, 2))
		else $error("result bus changed without executed rise");
	AST_RIPPLE_LOGIC: assert property ((up && $stable(instructionField) && instructionField[2:1] != 2'h0)[*4]
		|-> rippleCarryN == instructionField[0]) else $error("ripple out not passing lowest bit");
	AST_PG_LOWER: assert property ((up && $stable({topSliceSelect, instructionField}) && !topSliceSelect
		&& instructionField[2:1] != 2'h0)[*4] |-> !propagateN && generateN) else $error("lower slice pg wrong");
	AST_OVF_TOP: assert property ((up && $stable({topSliceSelect, instructionField}) && topSliceSelect
		&& instructionField[2:1] != 2'h0)[*4] |-> generateN) else $error("overflow flagged for logical op");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule

bind ars_slice_top ars_slice_chk #(.WIDTH(WIDTH)) chk (.core_clk, .reset, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sliceClock,
	.executeN, .outputEnableN, .topSliceSelect, .instructionField, .resultBusOutN, .resultBusOe, .rippleCarryN,
	.propagateN, .generateN, .zeroOut);

/* File: ars_slice_top.v */
/*
 * Arithmetic logic register stack slice: pin synchroniser, microcycle
 * phase logic, register RAM, ALU, output register, status pins and an
 * AXI4-Lite slave for control and observation.
 * Assumes the controller drives the slice pins from another clock domain,
 * slow compared with core_clk, and holds each level for several core cycles.
 */
`timescale 1ns/100ps
`include "ars_defs.vh"

// Summary of operation
// - eight ALU functions on two 4-bit operands, picked by 3-bit instruction
// - one operand from data bus, other from eight-word register RAM
// - clock high: operand latch follows the addressed register word
// - clock low: ALU result written to the word addressed then
// - rising slice clock loads ALU result into output register
// - output register drives bus when enable low, else bus floats
// - data bus inputs are active low
// - result bus outputs are active low
// - zero, negative, overflow and carry status provided
// - propagate and generate outputs for lookahead; ripple also works
// - top slice: propagate pin shows active-low negative
// - top slice: generate pin shows active-low overflow
// - lowest instruction bit is also the arithmetic carry in
// - active-low ripple carry out, passes instruction bit otherwise
// - zero output is open collector, active high, needs pull-up
// - active-low execute qualifies RAM write and output load
// - arithmetic when both upper instruction bits low, else logical
// - 4-bit slice, widened by cascading identical slices
// - decode: add+1, add, and, load, transfer, or, xor, load complement
// - RAM written only with clock and execute low; load needs execute low
// - ripple out is carry for arithmetic, lowest instruction bit otherwise
// - lower slices: propagate low, generate high for logical operations

module ars_slice_top #(
	parameter WIDTH = `ARS_SLICE_W,
	parameter DEPTH = `ARS_WORDS,
	parameter ADDR_W = `ARS_ADDR_W
) (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// axi4-lite write address
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// slice control pins
	input wire sliceClock,
	input wire executeN,
	input wire outputEnableN,
	input wire topSliceSelect,
	input wire [ADDR_W-1:0] registerAddressField,
	input wire [2:0] instructionField,
	// data pins
	input wire [WIDTH-1:0] dataBusInN,
	output wire [WIDTH-1:0] resultBusOutN,
	output wire resultBusOe,
	// expansion and status pins
	output wire rippleCarryN,
	output wire propagateN,
	output wire generateN,
	output wire zeroOut,
	output wire zeroOe
);

	localparam PIN_W = 4 + ADDR_W + 3 + WIDTH;

	// pin synchroniser
	reg [PIN_W-1:0] pinMeta_reg;
	reg [PIN_W-1:0] pinSync_reg;
	reg clkPrev_reg;
	wire syncClock;
	wire syncExecN;
	wire syncOeN;
	wire syncTop;
	wire [ADDR_W-1:0] syncAddr;
	wire [2:0] syncInstr;
	wire [WIDTH-1:0] syncDataN;
	wire clockRise;

	// datapath
	wire [WIDTH-1:0] latchData;
	wire [WIDTH-1:0] aluResult;
	wire aluArith;
	wire aluCarry;
	wire aluProp;
	wire aluGen;
	wire aluNeg;
	wire aluOvf;
	wire ramWrite;
	wire loadOut;

	// output side
	reg [WIDTH-1:0] busN_reg;
	reg busOe_reg;
	reg rippleN_reg;
	reg propN_reg;
	reg genN_reg;
	reg zeroOe_reg;
	reg [3:0] flags_reg;
	reg rippleN_next;
	reg propN_next;
	reg genN_next;

	// software side
	reg [1:0] ctrl_reg;
	reg [31:0] cycles_reg;
	reg [31:0] writes_reg;
	reg awHeld_reg;
	reg wHeld_reg;
	reg [`ARS_ADDR_BITS-1:0] awAddr_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_next;
	reg [1:0] rresp_next;
	wire [`ARS_ADDR_BITS-1:0] readAddr;
	wire writeFire;

	// every pin crosses two flip-flops; only the second stage is read
	always @(posedge core_clk) begin
		pinMeta_reg <= {sliceClock, executeN, outputEnableN, topSliceSelect,
			registerAddressField, instructionField, dataBusInN};
		pinSync_reg <= pinMeta_reg;
	end

	assign {syncClock, syncExecN, syncOeN, syncTop, syncAddr, syncInstr, syncDataN} = pinSync_reg;

	always @(posedge core_clk) begin
		if (reset) begin
			clkPrev_reg <= 1'b0;
		end else begin
			clkPrev_reg <= syncClock;
		end
	end

	assign clockRise = syncClock & ~clkPrev_reg;

	// hold lets software freeze the stack without touching the pins;
	// it is an extra inhibit only and never forces a write
	assign ramWrite = ~syncClock & ~syncExecN & ~ctrl_reg[`ARS_CTRL_HOLD];
	assign loadOut = clockRise & ~syncExecN & ~ctrl_reg[`ARS_CTRL_HOLD];

	// read enable while high makes the latch follow the RAM, then freeze
	ars_reg_ram #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.ADDR_W(ADDR_W)
	) uRam (
		.core_clk(core_clk),
		.writeEnable(ramWrite),
		.writeAddr(syncAddr),
		.writeData(aluResult),
		.readEnable(syncClock),
		.readAddr(syncAddr),
		.readData(latchData)
	);

	// data bus is inverted into true polarity before the ALU
	ars_alu #(
		.WIDTH(WIDTH)
	) uAlu (
		.regOperand(latchData),
		.dataOperand(~syncDataN),
		.instr(syncInstr),
		.result(aluResult),
		.arith(aluArith),
		.carryOut(aluCarry),
		.carryProp(aluProp),
		.carryGen(aluGen),
		.negative(aluNeg),
		.overflow(aluOvf)
	);

	// expansion pins follow the ALU every cycle, unqualified by execute
	always @* begin
		if (aluArith) begin
			rippleN_next = ~aluCarry;
		end else begin
			rippleN_next = syncInstr[`ARS_I_CIN];
		end
		if (syncTop) begin
			propN_next = ~aluNeg;
			genN_next = ~aluOvf;
		end else if (aluArith) begin
			propN_next = ~aluProp;
			genN_next = ~aluGen;
		end else begin
			propN_next = 1'b0;
			genN_next = 1'b1;
		end
	end

	// output register holds zero after core reset so the pins are defined
	always @(posedge core_clk) begin
		if (reset) begin
			busN_reg <= {WIDTH{1'b1}};
			busOe_reg <= 1'b0;
			rippleN_reg <= 1'b1;
			propN_reg <= 1'b0;
			genN_reg <= 1'b1;
			zeroOe_reg <= 1'b0;
			flags_reg <= 4'h0;
		end else begin
			if (loadOut) begin
				busN_reg <= ~aluResult;
			end
			busOe_reg <= ~syncOeN & ctrl_reg[`ARS_CTRL_DRIVE];
			rippleN_reg <= rippleN_next;
			propN_reg <= propN_next;
			genN_reg <= genN_next;
			zeroOe_reg <= |aluResult;
			flags_reg <= {aluArith & aluCarry, aluOvf, aluNeg, ~|aluResult};
		end
	end

	assign resultBusOutN = busN_reg;
	assign resultBusOe = busOe_reg;
	assign rippleCarryN = rippleN_reg;
	assign propagateN = propN_reg;
	assign generateN = genN_reg;
	// open collector: only ever pulls low, the pull-up gives the high
	assign zeroOut = 1'b0;
	assign zeroOe = zeroOe_reg;

	// event counters for software
	always @(posedge core_clk) begin
		if (reset) begin
			cycles_reg <= 32'h0;
			writes_reg <= 32'h0;
		end else begin
			if (clockRise) begin
				cycles_reg <= cycles_reg + 32'h1;
			end
			if (loadOut) begin
				writes_reg <= writes_reg + 32'h1;
			end
		end
	end

	// write channel: address and data taken in either order, one at a time
	assign s_axi_awready = ~awHeld_reg & ~bvalid_reg;
	assign s_axi_wready = ~wHeld_reg & ~bvalid_reg;
	assign writeFire = awHeld_reg & wHeld_reg & ~bvalid_reg;

	always @(posedge core_clk) begin
		if (reset) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= {`ARS_ADDR_BITS{1'b0}};
			wData_reg <= 32'h0;
			wStrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `ARS_RESP_OKAY;
			ctrl_reg <= `ARS_CTRL_RESET;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr[`ARS_ADDR_BITS-1:0];
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (writeFire) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				case (awAddr_reg)
					`ARS_OFS_CTRL: begin
						bresp_reg <= `ARS_RESP_OKAY;
						if (wStrb_reg[0]) begin
							ctrl_reg <= wData_reg[1:0];
						end
					end
					`ARS_OFS_STATUS: bresp_reg <= `ARS_RESP_OKAY;
					`ARS_OFS_CYCLES: bresp_reg <= `ARS_RESP_OKAY;
					`ARS_OFS_WRITES: bresp_reg <= `ARS_RESP_OKAY;
					default: bresp_reg <= `ARS_RESP_DECERR;
				endcase
			end else if (bvalid_reg & s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// read channel
	assign readAddr = s_axi_araddr[`ARS_ADDR_BITS-1:0];
	assign s_axi_arready = ~rvalid_reg;

	always @* begin
		rdata_next = 32'h0;
		rresp_next = `ARS_RESP_OKAY;
		case (readAddr)
			`ARS_OFS_CTRL: rdata_next[1:0] = ctrl_reg;
			`ARS_OFS_STATUS: begin
				rdata_next[`ARS_ST_OUT_LO+WIDTH-1:`ARS_ST_OUT_LO] = ~busN_reg;
				rdata_next[`ARS_ST_ZERO] = flags_reg[0];
				rdata_next[`ARS_ST_NEG] = flags_reg[1];
				rdata_next[`ARS_ST_OVF] = flags_reg[2];
				rdata_next[`ARS_ST_CARRY] = flags_reg[3];
				rdata_next[`ARS_ST_TOP] = syncTop;
				rdata_next[`ARS_ST_CLK] = syncClock;
				rdata_next[`ARS_ST_EXEC] = ~syncExecN;
			end
			`ARS_OFS_CYCLES: rdata_next = cycles_reg;
			`ARS_OFS_WRITES: rdata_next = writes_reg;
			default: rresp_next = `ARS_RESP_DECERR;
		endcase
	end

	always @(posedge core_clk) begin
		if (reset) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `ARS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid & ~rvalid_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rdata_next;
				rresp_reg <= rresp_next;
			end else if (rvalid_reg & s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

/* File: tb_top.sv */
/*
 * Bench for the slice: bus master tasks, controller model, one task per scenario.
 * Assumes the checker binds itself to the slice top.
 */
`timescale 1ns/100ps
module tb_top;
	reg core_clk;
	reg reset;
	reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	reg [3:0] s_axi_wstrb;
	reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire sliceClock, executeN, outputEnableN, topSliceSelect;
	wire [2:0] registerAddressField, instructionField;
	wire [3:0] dataBusInN, resultBusOutN;
	wire resultBusOe, rippleCarryN, propagateN, generateN, zeroOut, zeroOe;
	integer errCount, samplesChecked, tick;
	ars_slice_top dut (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sliceClock,
		.executeN, .outputEnableN, .topSliceSelect, .registerAddressField, .instructionField, .dataBusInN,
		.resultBusOutN, .resultBusOe, .rippleCarryN, .propagateN, .generateN, .zeroOut, .zeroOe);
	ars_ctrl_model ctl (.core_clk, .sliceClock, .executeN, .outputEnableN, .topSliceSelect,
		.registerAddressField, .instructionField, .dataBusInN);
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end
	task giveVerdict;
		begin
			if (errCount == 0 && samplesChecked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge core_clk) begin
		tick = tick + 1;
		if (tick == 20000) begin
			errCount = errCount + 1;
			giveVerdict;
		end
	end
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		begin
			samplesChecked = samplesChecked + 1;
			if (seen !== exp) begin
				errCount = errCount + 1;
				$display("[ERR] %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task axiW(input [31:0] a, input [31:0] d, output [1:0] r);
		begin
			@(posedge core_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			do begin
				@(posedge core_clk);
				if (s_axi_awready) s_axi_awvalid <= 1'h0;
				if (s_axi_wready) s_axi_wvalid <= 1'h0;
			end while (!s_axi_bvalid);
			r = s_axi_bresp;
			s_axi_bready <= 1'h0;
		end
	endtask
	task axiR(input [31:0] a, output [31:0] d, output [1:0] r);
		begin
			@(posedge core_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			do begin
				@(posedge core_clk);
				if (s_axi_arready) s_axi_arvalid <= 1'h0;
			end while (!s_axi_rvalid);
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'h0;
		end
	endtask
	function [7:0] aluRef(input [3:0] r, input [3:0] d, input [2:0] i);
		reg [4:0] s;
		reg [3:0] o, p, g;
		reg a;
		begin
			s = {1'h0, r} + {1'h0, d} + {4'h0, i == 3'h0};
			case (i)
				3'h2: o = r & d;
				3'h3: o = d;
				3'h4: o = r;
				3'h5: o = r | d;
				3'h6: o = r ^ d;
				3'h7: o = ~d;
				default: o = s[3:0];
			endcase
			a = i[2:1] == 2'h0;
			p = r | d;
			g = r & d;
			aluRef = {&p, g[3] | p[3] & g[2] | &p[3:2] & g[1] | &p[3:1] & g[0],
				a & s[4], a & (r[3] == d[3]) & (o[3] != r[3]), o};
		end
	endfunction
	task ucyc(input [2:0] src, input [2:0] dst, input [2:0] i, input [3:0] dn, input ex);
		begin
			ctl.phaseHigh(src, i, dn);
			ctl.phaseLow(dst, ex);
		end
	endtask
	// the rise of this cycle shows what the previous cycle left in the output register
	task obs(input [3:0] exp);
		begin
			ctl.phaseHigh(3'h0, 3'h4, 4'hf);
			chk("result bus", resultBusOutN, 4'hf ^ exp);
			ctl.phaseLow(3'h0, 1'h1);
		end
	endtask
	task tRegs;
		reg [31:0] d;
		reg [1:0] r;
		begin
			axiR(32'h0, d, r);
			chk("ctrl reset", d, 32'h1);
			axiW(32'h4, 32'hff, r);
			chk("ro write", r, 2'h0);
			axiR(32'h2, d, r);
			chk("unmapped rd data", d, 32'h0);
			chk("unmapped rd resp", r, 2'h3);
			axiW(32'h2, 32'h0, r);
			chk("unmapped wr", r, 2'h3);
		end
	endtask
	task tOe;
		reg [1:0] r;
		begin
			ctl.setMode(1'h0, 1'h0);
			repeat (4) @(posedge core_clk);
			chk("oe on", resultBusOe, 1'h1);
			axiW(32'h0, 32'h0, r);
			repeat (4) @(posedge core_clk);
			chk("oe gated", resultBusOe, 1'h0);
			axiW(32'h0, 32'h1, r);
			ctl.setMode(1'h0, 1'h1);
			repeat (4) @(posedge core_clk);
			chk("oe off", resultBusOe, 1'h0);
			ctl.setMode(1'h0, 1'h0);
		end
	endtask
	task tGen;
		begin
			ucyc(3'h2, 3'h2, 3'h3, 4'h5, 1'h0);
			ucyc(3'h1, 3'h1, 3'h3, 4'ha, 1'h0);
			ucyc(3'h1, 3'h2, 3'h4, 4'hf, 1'h0);
			ucyc(3'h2, 3'h2, 3'h4, 4'hf, 1'h0);
			obs(4'h5);
		end
	endtask
	task tExec;
		reg [31:0] c0, l0, c1, l1;
		reg [1:0] r;
		begin
			axiR(32'h8, c0, r);
			axiR(32'hc, l0, r);
			ucyc(3'h2, 3'h2, 3'h3, 4'h0, 1'h1);
			obs(4'h5);
			ucyc(3'h2, 3'h2, 3'h4, 4'hf, 1'h0);
			obs(4'h5);
			axiR(32'h8, c1, r);
			axiR(32'hc, l1, r);
			chk("rise count", c1 - c0, 32'h4);
			chk("load count", l1 - l0, 32'h1);
			// hold must stop both the stack write and the output load
			axiW(32'h0, 32'h3, r);
			axiR(32'h0, c0, r);
			chk("ctrl hold", c0, 32'h3);
			ucyc(3'h2, 3'h2, 3'h3, 4'h0, 1'h0);
			obs(4'h5);
			axiW(32'h0, 32'h1, r);
			ucyc(3'h2, 3'h2, 3'h4, 4'hf, 1'h0);
			obs(4'h5);
		end
	endtask
	task tOps(input top);
		integer k;
		reg [3:0] r, d, res;
		reg [7:0] expv;
		reg [31:0] st;
		reg [1:0] rsp;
		reg ar;
		begin
			ctl.setMode(top, 1'h0);
			for (k = 0; k < 8; k = k + 1) begin
				r = 4'(32'h061e0c97 >> (k * 4));
				d = 4'(32'h36205a70 >> (k * 4));
				ucyc(3'h0, 3'h0, 3'h3, 4'hf ^ r, 1'h0);
				ucyc(3'h0, 3'h0, k[2:0], 4'hf ^ d, 1'h0);
				expv = aluRef(r, d, k[2:0]);
				res = expv[3:0];
				ar = k < 2;
				axiR(32'h4, st, rsp);
				chk("flags", st[8:4], {top, expv[5], expv[4], res[3], res == 4'h0});
				chk("zero pin", zeroOe, res != 4'h0);
				chk("ripple", rippleCarryN, ar ? !expv[5] : k[0]);
				chk("propagate", propagateN, top ? !res[3] : (ar ? !expv[7] : 1'h0));
				chk("generate", generateN, top ? !expv[4] : (ar ? !expv[6] : 1'h1));
				obs(res);
			end
		end
	endtask
	initial begin
		reset = 1'h1;
		s_axi_awaddr = 32'h0;
		s_axi_wdata = 32'h0;
		s_axi_araddr = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		errCount = 0;
		samplesChecked = 0;
		tick = 0;
		repeat (5) @(posedge core_clk);
		reset <= 1'h0;
		repeat (3) @(posedge core_clk);
		tRegs;
		tOe;
		tGen;
		tExec;
		tOps(1'h0);
		tOps(1'h1);
		giveVerdict;
	end
endmodule
